//--- hdl/scwm_regs.svh
// Register indices, field positions, reset values and key codes of the clock/write monitor
// Function
// - Read-only protection status in oscillator control bit7
// - Control bit picks LCD clock: slow or timer3
// - External-input bit makes fast clock externally supplied
// - Fast oscillator drive bit: 1 normal, 0 weak
// - Three area detect enables at bits 6..4
// - Three area write flags at bits 2..0
// - Writing 0 clears a flag until next write
`ifndef SCWM_REGS_SVH
`define SCWM_REGS_SVH

// Register indices; byte address is four times the index
`define SCWM_IDX_SYSCTRL0   8'hE0
`define SCWM_IDX_SYSCTRL1   8'hE1
`define SCWM_IDX_SYSCTRL2   8'hE2
`define SCWM_IDX_OSCCTRL0   8'hE3
`define SCWM_IDX_KEY1       8'hE4
`define SCWM_IDX_KEY2       8'hE5
`define SCWM_IDX_AREAMON    8'hE6
`define SCWM_IDX_DBLCTRL0   8'hE8
`define SCWM_IDX_DBLCTRL1   8'hE9
`define SCWM_IDX_IRQSTAT    8'hF0
`define SCWM_IDX_IRQMASK    8'hF1

// Reset values
`define SCWM_RST_SYSCTRL0   8'hA0
`define SCWM_RST_SYSCTRL1   8'h04
`define SCWM_RST_SYSCTRL2   8'h2C
`define SCWM_RST_OSCCTRL0   8'h23
`define SCWM_RST_DBLCTRL0   8'h00
`define SCWM_RST_DBLCTRL1   8'h13

// Field positions
`define SCWM_BIT_PROTECT    7
`define SCWM_BIT_LCD_SRC    6
`define SCWM_BIT_FAST_EXT   2
`define SCWM_BIT_FAST_DRV   1
`define SCWM_BIT_SLOW_DRV   0
`define SCWM_BIT_DBL_LOCK   5
`define SCWM_MON_EN_LSB     4
`define SCWM_MON_EN_MSB     6

// Protection key codes
`define SCWM_KEY_A          8'h5A
`define SCWM_KEY_B          8'hA5

`endif

//--- hdl/scwm_pkg.sv
// Types shared by the clock and write monitor block
package scwm_pkg;

    // One bit per detection area: [2] area 1A, [1] areas 2B-2G, [0] area 2A
    typedef logic [2:0] scwm_area_t;

    // Stored configuration, driven straight to the clock tree
    typedef struct packed {
        logic [7:0] sysCtrl0;
        logic [7:0] sysCtrl1;
        logic [7:0] sysCtrl2;
        logic [7:0] oscCtrl0;
        logic [7:0] dblCtrl0;
        logic [7:0] dblCtrl1;
    } scwm_clk_cfg_s;

    // Protection key sequencer
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ON_ARMED,
        KEY_OFF_ARMED
    } scwm_key_e;

endpackage

//--- hdl/scwm_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module scwm_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule
`default_nettype wire

//--- hdl/scwm_sticky.sv
// Bank of sticky flags where a set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module scwm_sticky #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Events and clears
    input  wire logic [W-1:0] setEvt,
    input  wire logic [W-1:0] clrBits,
    // Flags
    output var  logic [W-1:0] flags
);

    logic [W-1:0] next_flags;

    // Set wins so an event in the clearing cycle survives
    assign next_flags = (flags & ~clrBits) | setEvt;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule
`default_nettype wire

//--- hdl/scwm_top.sv
// Clock control registers, protection keys and area write monitor behind Wishbone
`timescale 1ns/1ps
`default_nettype none
`include "scwm_regs.svh"
module scwm_top
    import scwm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rstn,
    // Wishbone classic slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]   wb_dat_i,
    output var  logic [31:0]   wb_dat_o,
    output var  logic          wb_ack_o,
    // Area write strobes from the chip-select pins, asynchronous
    input  wire scwm_area_t    areaWriteIn,
    // Clock configuration to the clock tree
    output var  scwm_clk_cfg_s clkCfg,
    output var  logic          protectOn,
    // Interrupt
    output var  logic          irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    generate
        if (ADDR_W < 11) begin : g_addrChk
            $error("scwm_top: ADDR_W must be at least 11");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic          busReq;
    logic          wrStb;
    logic          rdStb;
    logic [7:0]    regIdx;
    logic          upperZero;
    logic [7:0]    wByte;
    logic          selSys0;
    logic          selSys1;
    logic          selSys2;
    logic          selOsc0;
    logic          selKey1;
    logic          selKey2;
    logic          selMon;
    logic          selDbl0;
    logic          selDbl1;
    logic          selIrqStat;
    logic          selIrqMask;
    logic [7:0]    readByte;
    scwm_clk_cfg_s next_clkCfg;
    logic [7:0]    next_sysCtrl0;
    logic [7:0]    next_sysCtrl1;
    logic [7:0]    next_sysCtrl2;
    logic [7:0]    next_oscCtrl0;
    logic [7:0]    next_dblCtrl0;
    logic [7:0]    next_dblCtrl1;
    scwm_area_t    monEnable;
    scwm_area_t    next_monEnable;
    scwm_area_t    areaSync;
    scwm_area_t    areaPrev;
    scwm_area_t    areaRise;
    scwm_area_t    areaSet;
    scwm_area_t    areaClr;
    scwm_area_t    areaFlags;
    scwm_area_t    irqStat;
    scwm_area_t    irqClr;
    scwm_area_t    irqMask;
    scwm_area_t    next_irqMask;
    scwm_key_e     keyState;
    scwm_key_e     next_keyState;
    logic          next_protectOn;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Fresh request only; the acked cycle is not taken twice
    assign busReq     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrStb      = busReq & wb_we_i & wb_sel_i[0];
    assign rdStb      = busReq & ~wb_we_i;
    assign regIdx     = wb_adr_i[9:2];
    assign upperZero  = (wb_adr_i[ADDR_W-1:10] == '0);
    assign wByte      = wb_dat_i[7:0];
    assign selSys0    = upperZero & (regIdx == `SCWM_IDX_SYSCTRL0);
    assign selSys1    = upperZero & (regIdx == `SCWM_IDX_SYSCTRL1);
    assign selSys2    = upperZero & (regIdx == `SCWM_IDX_SYSCTRL2);
    assign selOsc0    = upperZero & (regIdx == `SCWM_IDX_OSCCTRL0);
    assign selKey1    = upperZero & (regIdx == `SCWM_IDX_KEY1);
    assign selKey2    = upperZero & (regIdx == `SCWM_IDX_KEY2);
    assign selMon     = upperZero & (regIdx == `SCWM_IDX_AREAMON);
    assign selDbl0    = upperZero & (regIdx == `SCWM_IDX_DBLCTRL0);
    assign selDbl1    = upperZero & (regIdx == `SCWM_IDX_DBLCTRL1);
    assign selIrqStat = upperZero & (regIdx == `SCWM_IDX_IRQSTAT);
    assign selIrqMask = upperZero & (regIdx == `SCWM_IDX_IRQMASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Register next values

    // Function merging a byte write into a stored register
    function automatic logic [7:0] wrMerge(input logic hit, input logic [7:0] cur,
                                          input logic [7:0] val);
        wrMerge = hit ? val : cur;
    endfunction

    assign next_sysCtrl0 = wrMerge(wrStb & selSys0, clkCfg.sysCtrl0, wByte);
    assign next_sysCtrl1 = wrMerge(wrStb & selSys1, clkCfg.sysCtrl1, {4'h0, wByte[3:0]});
    assign next_sysCtrl2 = wrMerge(wrStb & selSys2, clkCfg.sysCtrl2, {1'b0, wByte[6:0]});
    // Protect position never stored from the bus
    assign next_oscCtrl0 = wrMerge(wrStb & selOsc0, clkCfg.oscCtrl0, {1'b0, wByte[6:0]});
    // Lock flag has no lock-up logic behind it and stays clear
    assign next_dblCtrl0 = wrMerge(wrStb & selDbl0, clkCfg.dblCtrl0,
                                   {wByte[7:6], 1'b0, wByte[4], 4'h0});
    assign next_dblCtrl1 = wrMerge(wrStb & selDbl1, clkCfg.dblCtrl1, wByte);
    assign next_clkCfg   = {next_sysCtrl0, next_sysCtrl1, next_sysCtrl2,
                            next_oscCtrl0, next_dblCtrl0, next_dblCtrl1};

    // Area detect enables
    assign next_monEnable = (wrStb & selMon) ?
                            wByte[`SCWM_MON_EN_MSB:`SCWM_MON_EN_LSB] : monEnable;
    assign next_irqMask   = (wrStb & selIrqMask) ? wByte[2:0] : irqMask;

    // Configuration registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clkCfg <= {`SCWM_RST_SYSCTRL0, `SCWM_RST_SYSCTRL1, `SCWM_RST_SYSCTRL2,
                       `SCWM_RST_OSCCTRL0, `SCWM_RST_DBLCTRL0, `SCWM_RST_DBLCTRL1};
            monEnable <= 3'h0;
            irqMask   <= 3'h0;
        end else begin
            clkCfg    <= next_clkCfg;
            monEnable <= next_monEnable;
            irqMask   <= next_irqMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protection key sequencer

    // Key1 arms, key2 completes; any other key value disarms
    always_comb begin
        next_keyState = keyState;
        if (wrStb & selKey1) begin
            if (wByte == `SCWM_KEY_A) begin
                next_keyState = KEY_ON_ARMED;
            end else if (wByte == `SCWM_KEY_B) begin
                next_keyState = KEY_OFF_ARMED;
            end else begin
                next_keyState = KEY_IDLE;
            end
        end else if (wrStb & selKey2) begin
            next_keyState = KEY_IDLE;
        end
    end

    // Only a completed key pair moves the protect bit
    always_comb begin
        next_protectOn = protectOn;
        if (wrStb & selKey2) begin
            case (keyState)
                KEY_ON_ARMED: begin
                    next_protectOn = (wByte == `SCWM_KEY_B) ? 1'b1 : protectOn;
                end
                KEY_OFF_ARMED: begin
                    next_protectOn = (wByte == `SCWM_KEY_A) ? 1'b0 : protectOn;
                end
                default: begin
                    next_protectOn = protectOn;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            keyState  <= KEY_IDLE;
            protectOn <= 1'b0;
        end else begin
            keyState  <= next_keyState;
            protectOn <= next_protectOn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Area write detection

    scwm_sync #(
        .W (3)
    ) u_areaSync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .d       (areaWriteIn),
        .q       (areaSync)
    );

    // Edge found on the synchronised copy, one flag event per strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            areaPrev <= 3'h0;
        end else begin
            areaPrev <= areaSync;
        end
    end

    assign areaRise = areaSync & ~areaPrev;
    assign areaSet  = areaRise & monEnable;
    // Writing 0 clears; writing 1 leaves the flag alone
    assign areaClr  = (wrStb & selMon) ? ~wByte[2:0] : 3'h0;

    scwm_sticky #(
        .W (3)
    ) u_areaFlags (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .setEvt  (areaSet),
        .clrBits (areaClr),
        .flags   (areaFlags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear

    assign irqClr = (wrStb & selIrqStat) ? wByte[2:0] : 3'h0;

    scwm_sticky #(
        .W (3)
    ) u_irqStat (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .setEvt  (areaSet),
        .clrBits (irqClr),
        .flags   (irqStat)
    );

    // Registered so the pin is glitch free, at one cycle of latency
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path and acknowledge

    // Key registers and unmapped indices read zero
    assign readByte =
        selSys0    ? clkCfg.sysCtrl0 :
        selSys1    ? clkCfg.sysCtrl1 :
        selSys2    ? clkCfg.sysCtrl2 :
        selOsc0    ? {protectOn, clkCfg.oscCtrl0[6:0]} :
        selMon     ? {1'b0, monEnable, 1'b0, areaFlags} :
        selDbl0    ? clkCfg.dblCtrl0 :
        selDbl1    ? clkCfg.dblCtrl1 :
        selIrqStat ? {5'h00, irqStat} :
        selIrqMask ? {5'h00, irqMask} : 8'h00;

    // Single wait state answer, ack drops the cycle after
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= rdStb ? {24'h000000, readByte} : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_protect_only_by_key;
        $changed(protectOn) |-> $past(wrStb & selKey2);
    endproperty
    a_protect_only_by_key: assert property (p_protect_only_by_key)
        else $error("protect bit moved without a key2 write");

    property p_protect_readback;
        rdStb && selOsc0 |=> wb_ack_o && (wb_dat_o[7] == $past(protectOn));
    endproperty
    a_protect_readback: assert property (p_protect_readback)
        else $error("protect status not shown at bit 7");

    property p_lcd_src;
        wrStb && selOsc0 |=> clkCfg.oscCtrl0[`SCWM_BIT_LCD_SRC] == $past(wb_dat_i[6]);
    endproperty
    a_lcd_src: assert property (p_lcd_src)
        else $error("lcd clock source bit not stored");

    property p_fast_ext;
        wrStb && selOsc0 ##1 !(wrStb && selOsc0)
            |-> clkCfg.oscCtrl0[`SCWM_BIT_FAST_EXT] == $past(wb_dat_i[2]);
    endproperty
    a_fast_ext: assert property (p_fast_ext)
        else $error("external fast clock bit not held");

    property p_fast_drv;
        wrStb && selOsc0 && wb_dat_i[1] |-> ##1 clkCfg.oscCtrl0[`SCWM_BIT_FAST_DRV];
    endproperty
    a_fast_drv: assert property (p_fast_drv)
        else $error("fast oscillator drive bit not set");

    property p_enable_store;
        wrStb && selMon |=> monEnable == $past(wb_dat_i[6:4]);
    endproperty
    a_enable_store: assert property (p_enable_store)
        else $error("area detect enables not stored");

    property p_flag_set;
        areaSet != 3'h0 |=> (areaFlags & $past(areaSet)) == $past(areaSet) [*2];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("write flag lost after detection");

    property p_flag_clear;
        wrStb && selMon && !wb_dat_i[0] && !areaSet[0] ##1 !areaSet[0]
            |-> !areaFlags[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("write flag not cleared by writing zero");

    property p_flag_needs_enable;
        ((areaFlags & ~$past(areaFlags)) & ~$past(monEnable)) == 3'h0;
    endproperty
    a_flag_needs_enable: assert property (p_flag_needs_enable)
        else $error("write flag set while detection disabled");

    property p_ack_pulse;
        busReq |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a one-cycle answer");

    property p_irq_level;
        ##1 irq == $past(|(irqStat & irqMask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with status and mask");

    c_flag_set:   cover property (areaSet[2] ##1 areaFlags[2]);
    c_protect_on: cover property ($rose(protectOn));
    c_irq:        cover property ($rose(irq));
    c_set_clear:  cover property (areaSet[1] && areaClr[1]);

endmodule
`default_nettype wire

//--- testbench/test_scwm_top.sv
// Self-checking testbench for the clock control and area write monitor block
`timescale 1ns/1ps
`default_nettype none
`include "scwm_regs.svh"

// One comparison, counted, mismatch reported at once
`define CHK(nm, exp, got) \
    begin \
        testsRun++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module test_scwm_top
    import scwm_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////
    // Stimulus and observation signals
    logic          ref_clk   = 1'b0;
    logic          rstn      = 1'b0;
    logic          wbCyc     = 1'b0;
    logic          wbStb     = 1'b0;
    logic          wbWe      = 1'b0;
    logic [3:0]    wbSel     = 4'hF;
    logic [11:0]   wbAdr     = 12'h000;
    logic [31:0]   wbDat     = 32'h00000000;
    logic [31:0]   wbRdat;
    logic          wbAck;
    scwm_area_t    areaIn    = 3'h0;
    scwm_clk_cfg_s clkCfg;
    logic          protectOn;
    logic          irq;
    int            failures  = 0;
    int            testsRun  = 0;
    logic [7:0]    expQ[$];
    string         nameQ[$];

    scwm_top #(
        .ADDR_W      (12)
    ) dut (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .wb_cyc_i    (wbCyc),
        .wb_stb_i    (wbStb),
        .wb_we_i     (wbWe),
        .wb_sel_i    (wbSel),
        .wb_adr_i    (wbAdr),
        .wb_dat_i    (wbDat),
        .wb_dat_o    (wbRdat),
        .wb_ack_o    (wbAck),
        .areaWriteIn (areaIn),
        .clkCfg      (clkCfg),
        .protectOn   (protectOn),
        .irq         (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Read answers are judged at the ack edge against the oldest note
    always @(posedge ref_clk) begin : readCheck
        logic [7:0] e;
        string      s;
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (expQ.size() == 0) begin
                failures++;
                $display("wrong value read answer expected none seen %0h", wbRdat);
            end else begin
                // Pop once each so the macro never pops twice
                e = expQ.pop_front();
                s = nameQ.pop_front();
                `CHK(s, {24'h000000, e}, wbRdat)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classic single cycle; entered just after a rising edge, leaves after one
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe  <= we;
        wbAdr <= {2'b00, idx, 2'b00};
        wbDat <= {24'h000000, d};
        @(posedge ref_clk);
        while (wbAck !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 100) begin
            failures++;
        end
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        // Idle cycle between requests
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    // Note the expectation first, then issue the read
    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        nameQ.push_back(nm);
        bus(1'b0, idx, 8'h00);
    endtask

    // One write event on an area strobe; high and low well over two cycles
    task automatic pulse(input int i);
        areaIn[i] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        areaIn[i] <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the roughly two hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] vals[4];
        logic [7:0] v;
        void'($urandom(32'h41C9DD2D));
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        // Reset state: protect off, slow LCD clock, crystal, normal drive
        rd("osc ctrl reset", `SCWM_IDX_OSCCTRL0, 8'h23);
        rd("monitor reset", `SCWM_IDX_AREAMON, 8'h00);
        `CHK("protect reset", 1'b0, protectOn)
        `CHK("irq reset", 1'b0, irq)
        `CHK("cfg reset", {`SCWM_RST_SYSCTRL0, `SCWM_RST_SYSCTRL1, `SCWM_RST_SYSCTRL2, `SCWM_RST_OSCCTRL0, `SCWM_RST_DBLCTRL0, `SCWM_RST_DBLCTRL1}, clkCfg)
        // LCD source, external input, all clear, then one random pattern; the protect bit stays 0
        vals[0] = 8'h40;
        vals[1] = 8'h84;
        vals[2] = 8'h00;
        vals[3] = 8'($urandom());
        for (int k = 0; k < 4; k++) begin
            v = vals[k];
            wr(`SCWM_IDX_OSCCTRL0, v);
            rd("osc ctrl", `SCWM_IDX_OSCCTRL0, {1'b0, v[6:0]});
            `CHK("osc cfg", v[6:0], clkCfg.oscCtrl0[6:0])
        end
        // Low byte not selected: the write is acked but changes nothing
        wbSel <= 4'hE;
        wr(`SCWM_IDX_OSCCTRL0, ~v);
        wbSel <= 4'hF;
        rd("osc unselected", `SCWM_IDX_OSCCTRL0, {1'b0, v[6:0]});
        // Protection on by the key pair; a write cannot touch the status bit
        wr(`SCWM_IDX_KEY1, 8'h5A);
        wr(`SCWM_IDX_KEY2, 8'hA5);
        `CHK("protect on", 1'b1, protectOn)
        wr(`SCWM_IDX_OSCCTRL0, 8'h23);
        rd("osc protected", `SCWM_IDX_OSCCTRL0, 8'hA3);
        wr(`SCWM_IDX_KEY1, 8'hA5);
        wr(`SCWM_IDX_KEY2, 8'h5A);
        `CHK("protect off", 1'b0, protectOn)
        rd("osc unprotected", `SCWM_IDX_OSCCTRL0, 8'h23);
        // Write-only key and unmapped place read zero
        rd("key read", `SCWM_IDX_KEY1, 8'h00);
        rd("unmapped", 8'hE7, 8'h00);
        // Every area sets its own flag, and writing 0 clears only that one
        wr(`SCWM_IDX_IRQMASK, 8'h07);
        wr(`SCWM_IDX_AREAMON, 8'h70);
        rd("enables", `SCWM_IDX_AREAMON, 8'h70);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            rd("flag set", `SCWM_IDX_AREAMON, 8'h70 | (8'h01 << i));
            `CHK("irq set", 1'b1, irq)
            wr(`SCWM_IDX_AREAMON, 8'h70 | (8'h07 & ~(8'h01 << i)));
            rd("flag clear", `SCWM_IDX_AREAMON, 8'h70);
        end
        pulse(1);
        rd("flag again", `SCWM_IDX_AREAMON, 8'h72);
        // Interrupt masked, unmasked, then cleared by writing ones
        rd("irq status", `SCWM_IDX_IRQSTAT, 8'h07);
        wr(`SCWM_IDX_IRQMASK, 8'h00);
        `CHK("irq masked", 1'b0, irq)
        wr(`SCWM_IDX_IRQMASK, 8'h02);
        `CHK("irq unmasked", 1'b1, irq)
        wr(`SCWM_IDX_IRQSTAT, 8'h07);
        `CHK("irq cleared", 1'b0, irq)
        rd("irq status clr", `SCWM_IDX_IRQSTAT, 8'h00);
        // Writing 1 keeps a flag, writing 0 clears it; only enabled areas record
        wr(`SCWM_IDX_AREAMON, 8'h12);
        rd("flag kept", `SCWM_IDX_AREAMON, 8'h12);
        wr(`SCWM_IDX_AREAMON, 8'h10);
        pulse(2);
        pulse(1);
        rd("disabled areas", `SCWM_IDX_AREAMON, 8'h10);
        pulse(0);
        rd("enabled area", `SCWM_IDX_AREAMON, 8'h11);
        rd("status enabled", `SCWM_IDX_IRQSTAT, 8'h01);
        repeat (4) @(posedge ref_clk);
        `CHK("reads answered", 0, expQ.size())
        stop_test();
    end
endmodule
`default_nettype wire
